// file: rtl/ltc_regs.v
// control and diagnostic registers of the line transceiver
`timescale 1ns/1ns
`include "ltc_defs.vh"
module ltc_regs (
  input wire clk_in, // 10 MHz system clock
  input wire rst_n_in, // sync reset, active low
  input wire bit_en_in, // control-channel bit strobe
  input wire control_serial_input_in, // control channel serial data
  input wire byte_last_in, // strobe on last control bit
  input wire frame_pulse_in, // one-cycle frame pulse
  input wire two_port_mode_in, // high in two-port operation
  input wire strap_default_in, // sample strap into default mode
  output wire convergence_speedup_out, // fast echo convergence
  output wire tx_housekeeping_bit_out, // housekeeping bit to line
  output wire line_rate_select_out, // 1: 160k, 0: 80k
  output wire signalling_in_voice_slot_out, // d channel in b1 slot
  output wire scrambler_option_out, // scrambler option
  output wire force_out_of_sync_out, // drop frame sync
  output wire scrambler_swap_out, // scrambler swap diagnostic
  output wire line_output_disable_out, // line out at bias
  output wire loop_system_out, // system in looped to system out
  output wire loop_line_out, // line tx looped to receiver
  output reg [7:0] line_control_out, // control register value
  output reg [7:0] diagnostic_control_out // diagnostic register value
);
  // captured byte and its strobe
  wire [7:0] rx_byte;
  wire rx_valid;
  // select field decode
  wire [1:0] sel_field;
  reg sel_ctrl;
  reg sel_diag;
  wire ctrl_wr;
  wire diag_wr;
  // default mode decode
  wire [3:0] default_field;
  wire is_default;
  wire default_pick;
  reg [7:0] default_val;
  reg [7:0] strap_val;
  reg [7:0] ctrl_load;
  wire strap_on;
  // clear scheduling
  wire clear_req_bit;
  wire frame_clear;
  reg clear_pending;
  // next values
  reg [7:0] next_ctrl;
  reg [7:0] next_diag;
  reg next_clear;
  // loopback decode
  wire [1:0] lb_code;
  reg loop_sys;
  reg loop_line;

  ltc_byte_shift u_shift (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .bit_en_in(bit_en_in),
    .bit_in(control_serial_input_in),
    .last_in(byte_last_in),
    .byte_out(rx_byte),
    .valid_out(rx_valid)
  );

  assign sel_field = rx_byte[`LTC_SEL_HI:`LTC_SEL_LO];
  always @* begin
    sel_ctrl = 1'b0;
    sel_diag = 1'b0;
    case (sel_field)
      `LTC_SEL_CTRL: begin
        sel_ctrl = 1'b1;
      end
      `LTC_SEL_DIAG: begin
        sel_diag = 1'b1;
      end
      default: begin
        // bit 0 set addresses nothing; the byte is dropped
        sel_ctrl = 1'b0;
        sel_diag = 1'b0;
      end
    endcase
  end
  assign ctrl_wr = rx_valid & sel_ctrl;
  assign diag_wr = rx_valid & sel_diag;

  assign default_field = rx_byte[`LTC_DEF_HI:`LTC_DEF_LO];
  assign is_default = (default_field == `LTC_DEF_ALL);
  assign default_pick = rx_byte[`LTC_BIT_RATE];
  assign strap_on = two_port_mode_in & strap_default_in;

  // default byte: bit 3 picks which of the two modes
  always @* begin
    if (default_pick) begin
      default_val = `LTC_DEFAULT2_VAL;
    end else begin
      default_val = `LTC_DEFAULT1_VAL;
    end
  end

  // strap: the serial pin's own level picks the mode
  always @* begin
    if (control_serial_input_in) begin
      strap_val = `LTC_DEFAULT2_VAL;
    end else begin
      strap_val = `LTC_DEFAULT1_VAL;
    end
  end

  // literal settings unless bits 4 to 7 are all set
  always @* begin
    if (is_default) begin
      ctrl_load = default_val;
    end else begin
      ctrl_load = rx_byte;
    end
  end

  assign clear_req_bit = ctrl_load[`LTC_BIT_CLEAR_REQ];
  assign frame_clear = frame_pulse_in & clear_pending;

  // strap outranks a byte arriving in the same cycle
  always @* begin
    next_ctrl = line_control_out;
    if (strap_on) begin
      next_ctrl = strap_val;
    end else if (ctrl_wr) begin
      next_ctrl = ctrl_load;
    end
  end

  // a pending clear acts at the frame pulse; a write in that same
  // cycle lands afterwards, so the new settings are not lost
  always @* begin
    next_diag = diagnostic_control_out;
    if (frame_clear) begin
      next_diag = `LTC_DIAG_RESET;
    end
    if (strap_on) begin
      next_diag = `LTC_DIAG_RESET;
    end else if (ctrl_wr && is_default) begin
      // defaults disable every diagnostic
      next_diag = `LTC_DIAG_RESET;
    end else if (diag_wr) begin
      next_diag = rx_byte;
    end
  end

  // a new request wins over the frame pulse that consumes the old one
  always @* begin
    next_clear = clear_pending;
    if (frame_clear) begin
      next_clear = 1'b0;
    end
    if (strap_on) begin
      next_clear = 1'b1;
    end else if (ctrl_wr) begin
      next_clear = ~clear_req_bit;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      line_control_out <= `LTC_CTRL_RESET;
    end else begin
      line_control_out <= next_ctrl;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      diagnostic_control_out <= `LTC_DIAG_RESET;
    end else begin
      diagnostic_control_out <= next_diag;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      clear_pending <= 1'b0;
    end else begin
      clear_pending <= next_clear;
    end
  end

  // timing is the controller's job; only the bit is held here
  assign convergence_speedup_out =
    line_control_out[`LTC_BIT_SPEEDUP];
  assign tx_housekeeping_bit_out =
    line_control_out[`LTC_BIT_HOUSEKEEPING];
  assign line_rate_select_out = line_control_out[`LTC_BIT_RATE];
  assign signalling_in_voice_slot_out =
    line_control_out[`LTC_BIT_VOICE_SLOT];
  assign scrambler_option_out = line_control_out[`LTC_BIT_SCRAMBLER];

  assign force_out_of_sync_out =
    diagnostic_control_out[`LTC_BIT_UNSYNC];
  assign scrambler_swap_out = diagnostic_control_out[`LTC_BIT_SWAP];
  assign line_output_disable_out =
    diagnostic_control_out[`LTC_BIT_LINE_OFF];

  // code is {bit 2, bit 3}; code 11 is left as no loopback
  assign lb_code = {diagnostic_control_out[`LTC_BIT_LB_FIRST],
    diagnostic_control_out[`LTC_BIT_LB_SECOND]};
  always @* begin
    loop_sys = 1'b0;
    loop_line = 1'b0;
    case (lb_code)
      `LTC_LB_SYS: begin
        loop_sys = 1'b1;
      end
      `LTC_LB_LINE: begin
        loop_line = 1'b1;
      end
      default: begin
        loop_sys = 1'b0;
        loop_line = 1'b0;
      end
    endcase
  end
  assign loop_system_out = loop_sys;
  assign loop_line_out = loop_line;
endmodule

// file: inc/ltc_defs.vh
// constants for the line transceiver control register block
`ifndef LTC_DEFS_VH
`define LTC_DEFS_VH
`define LTC_SEL_HI 1
`define LTC_SEL_LO 0
// select field is {bit 1, bit 0}
`define LTC_SEL_CTRL 2'h0
`define LTC_SEL_DIAG 2'h2
`define LTC_CTRL_RESET 8'h00
`define LTC_DIAG_RESET 8'h00
`define LTC_DEFAULT1_VAL 8'h00
// bit string runs bit 0 first, so only the rate bit is set
`define LTC_DEFAULT2_VAL 8'h08
`define LTC_BIT_CLEAR_REQ 2
`define LTC_BIT_RATE 3
`define LTC_BIT_VOICE_SLOT 4
`define LTC_BIT_SCRAMBLER 5
`define LTC_BIT_SPEEDUP 6
`define LTC_BIT_HOUSEKEEPING 7
`define LTC_BIT_LB_FIRST 2
`define LTC_BIT_LB_SECOND 3
`define LTC_BIT_UNSYNC 4
`define LTC_BIT_SWAP 5
`define LTC_BIT_LINE_OFF 6
`define LTC_DEF_HI 7
`define LTC_DEF_LO 4
`define LTC_DEF_ALL 4'hF
`define LTC_LB_NONE 2'h0
`define LTC_LB_SYS 2'h1
`define LTC_LB_LINE 2'h2
`endif

// file: rtl/ltc_byte_shift.v
// serial to parallel capture of one control-channel byte
`timescale 1ns/1ns
module ltc_byte_shift (
  input wire clk_in, // system clock
  input wire rst_n_in, // sync reset, active low
  input wire bit_en_in, // one-cycle bit strobe
  input wire bit_in, // serial data, lsb first
  input wire last_in, // strobe marks final bit of byte
  output reg [7:0] byte_out, // captured byte
  output reg valid_out // one-cycle pulse after last bit
);
  reg [6:0] shift;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      shift <= 7'h00;
      byte_out <= 8'h00;
      valid_out <= 1'b0;
    end else begin
      valid_out <= 1'b0;
      if (bit_en_in) begin
        // lsb arrives first, so bit 0 ends lowest
        shift <= {bit_in, shift[6:1]};
        if (last_in) begin
          byte_out <= {bit_in, shift};
          valid_out <= 1'b1;
        end
      end
    end
  end
endmodule

// file: bench/ltc_ctrl_model.sv
// controller model that shifts control-channel bytes into the block
`timescale 1ns/1ns
module ltc_ctrl_model (
  input wire clk_in, // system clock
  output reg bit_en_out = 1'h0, // bit strobe
  output reg bit_out = 1'h0, // serial data, lsb first
  output reg last_out = 1'h0 // marks bit 7
);
  integer i;
  // select bits go first
  task send(input [7:0] b);
    for (i = 0; i < 8; i = i + 1) begin
      @(negedge clk_in);
      {bit_en_out, bit_out, last_out} = {1'h1, b[i], i == 7};
    end
    @(negedge clk_in);
    // idle line shows no stale bit
    {bit_en_out, bit_out, last_out} = {1'h0, ~b[7], 1'h0};
  endtask
  task level(input v);
    bit_out = v;
  endtask
endmodule

// file: bench/ltc_regs_sva.sv
// assertions on the register block ports
`timescale 1ns/1ns
module ltc_regs_sva (
  input wire clk_in, // system clock
  input wire rst_n_in, // sync reset, active low
  input wire bit_en_in, // bit strobe
  input wire byte_last_in, // last bit marker
  input wire frame_pulse_in, // frame pulse
  input wire two_port_mode_in, // two-port operation
  input wire strap_default_in, // strap request
  input wire control_serial_input_in, // serial pin level
  input wire convergence_speedup_out, // fast convergence
  input wire tx_housekeeping_bit_out, // housekeeping bit
  input wire force_out_of_sync_out, // forced unsync
  input wire line_output_disable_out, // line out at bias
  input wire loop_system_out, // system loopback
  input wire loop_line_out, // line loopback
  input wire [7:0] line_control_out, // control register
  input wire [7:0] diagnostic_control_out // diagnostic register
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  wire last_w = bit_en_in && byte_last_in;
  wire strap_w = two_port_mode_in && strap_default_in;
  wire [7:0] c = line_control_out;
  wire [7:0] d = diagnostic_control_out;
  sequence strap_s;
    strap_w;
  endsequence
  speedup_map_a: assert property (convergence_speedup_out == c[6])
    else $error("speedup");
  hk_map_a: assert property (tx_housekeeping_bit_out == c[7])
    else $error("housekeeping");
  unsync_map_a: assert property (force_out_of_sync_out == d[4])
    else $error("unsync");
  line_off_a: assert property (line_output_disable_out == d[6])
    else $error("line off");
  loop_map_a: assert property ({loop_system_out, loop_line_out} ==
    {d[3:2] == 2'h2, d[3:2] == 2'h1}) else $error("loopback");
  no_default_a: assert property (c[7:4] != 4'hF)
    else $error("default kept");
  strap_load_a: assert property (strap_s |=> d == 8'h00 &&
    c == {4'h0, $past(control_serial_input_in), 3'h0}) else $error("strap");
  ctrl_cause_a: assert property ($changed(c) |->
    $past(last_w, 2) || $past(strap_w)) else $error("ctrl change");
  diag_cause_a: assert property ($changed(d) |-> $past(last_w, 2) ||
    $past(frame_pulse_in) || $past(strap_w)) else $error("diag change");
endmodule
bind ltc_regs ltc_regs_sva chk_u (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .bit_en_in(bit_en_in),
  .byte_last_in(byte_last_in),
  .frame_pulse_in(frame_pulse_in),
  .two_port_mode_in(two_port_mode_in),
  .strap_default_in(strap_default_in),
  .control_serial_input_in(control_serial_input_in),
  .convergence_speedup_out(convergence_speedup_out),
  .tx_housekeeping_bit_out(tx_housekeeping_bit_out),
  .force_out_of_sync_out(force_out_of_sync_out),
  .line_output_disable_out(line_output_disable_out),
  .loop_system_out(loop_system_out),
  .loop_line_out(loop_line_out),
  .line_control_out(line_control_out),
  .diagnostic_control_out(diagnostic_control_out)
);

// file: bench/tb.sv
// self-checking bench for the line transceiver registers
`timescale 1ns/1ns
module tb;
  reg clk_in, rst_n_in = 0, frame = 0, two_port = 0, strap = 0;
  wire en, ser, last, spd, hk, unsync, line_off, lsys, lline;
  wire rate, vslot, scr, swap;
  wire [7:0] ctrl, diag;
  integer failures = 0, compares = 0, cyc = 0, i;
  ltc_ctrl_model mdl_u (.clk_in(clk_in), .bit_en_out(en), .bit_out(ser),
    .last_out(last));
  ltc_regs dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .bit_en_in(en),
    .control_serial_input_in(ser), .byte_last_in(last),
    .frame_pulse_in(frame), .two_port_mode_in(two_port),
    .strap_default_in(strap), .convergence_speedup_out(spd),
    .tx_housekeeping_bit_out(hk), .line_rate_select_out(rate),
    .signalling_in_voice_slot_out(vslot), .scrambler_option_out(scr),
    .force_out_of_sync_out(unsync), .scrambler_swap_out(swap),
    .line_output_disable_out(line_off), .loop_system_out(lsys),
    .loop_line_out(lline), .line_control_out(ctrl),
    .diagnostic_control_out(diag));
  task chk(input string nm, input [7:0] e, input [7:0] g);
    compares = compares + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("Error %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] b);
    mdl_u.send(b);
    @(negedge clk_in);
  endtask
  task pulse;
    @(negedge clk_in) frame = 1;
    @(negedge clk_in) frame = 0;
  endtask
  task test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk_in = 0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      failures = failures + 1;
      test_done;
    end
  end
  initial begin
    repeat (8) @(negedge clk_in);
    rst_n_in = 1;
    chk("reset ctrl", 8'h00, ctrl);
    chk("reset diag", 8'h00, diag);
    wr(8'hC4);
    chk("ctrl", 8'hC4, ctrl);
    chk("spd hk", 8'h03, {6'h00, spd, hk});
    chk("ctrl fields", 8'h00, {5'h00, rate, vslot, scr});
    wr(8'h56);
    chk("diag", 8'h56, diag);
    chk("diag bits", 8'h0D,
      {3'h0, swap, unsync, line_off, lsys, lline});
    pulse;
    chk("diag kept", 8'h56, diag);
    wr(8'h0A);
    chk("loop sys", 8'h02, {4'h0, unsync, line_off, lsys, lline});
    wr(8'h03);
    wr(8'hF1);
    chk("refused ctrl", 8'hC4, ctrl);
    chk("refused diag", 8'h0A, diag);
    wr(8'h40);
    chk("armed", 8'h0A, diag);
    pulse;
    chk("cleared", 8'h00, diag);
    wr(8'hF4);
    chk("default1", 8'h00, ctrl);
    wr(8'hF8);
    chk("default2", 8'h08, ctrl);
    chk("default2 rate", 8'h01, {7'h00, rate});
    for (i = 0; i < 2; i = i + 1) begin
      @(negedge clk_in);
      mdl_u.level(i[0]);
      {two_port, strap} = 2'h3;
      @(negedge clk_in) strap = 0;
      chk("strap", {4'h0, i[0], 3'h0}, ctrl);
    end
    two_port = 0;
    wr(8'h4C);
    repeat (240) pulse;
    chk("hold 160k", 8'h03, {6'h00, spd, rate});
    wr(8'h44);
    repeat (480) pulse;
    chk("hold 80k", 8'h02, {6'h00, spd, rate});
    wr(8'h04);
    chk("speedup off", 8'h00, {6'h00, spd, rate});
    wr(8'h3C);
    chk("ctrl fields", 8'h07, {5'h00, rate, vslot, scr});
    wr(8'h22);
    chk("swap", 8'h10, {3'h0, swap, unsync, line_off, lsys, lline});
    test_done;
  end
endmodule
